// file: hdl/pin_mux_pkg.sv
package pin_mux_pkg;

  // Pin positions inside every pin-indexed vector
  localparam int N_PINS  = 5;
  localparam int PIN_TCK = 0;  // Package pin 1
  localparam int PIN_RST = 1;  // Package pin 2
  localparam int PIN_C0  = 2;  // Package pin 3
  localparam int PIN_C1  = 3;  // Package pin 4
  localparam int PIN_C2  = 4;  // Package pin 5

  // Function code of one pin; code zero is always the primary function
  typedef logic [2:0] pin_fn_t;

  localparam pin_fn_t FN_TCK_TEST         = 3'h0;
  localparam pin_fn_t FN_TCK_GPIO         = 3'h1;
  localparam pin_fn_t FN_RST_PIN          = 3'h0;
  localparam pin_fn_t FN_RST_GPIO         = 3'h1;
  localparam pin_fn_t FN_C0_GPIO          = 3'h0;
  localparam pin_fn_t FN_C0_CRYSTAL_IN    = 3'h1;
  localparam pin_fn_t FN_C0_EXT_CLOCK_IN0 = 3'h2;
  localparam pin_fn_t FN_C1_GPIO          = 3'h0;
  localparam pin_fn_t FN_C1_CRYSTAL_OUT   = 3'h1;
  localparam pin_fn_t FN_C2_GPIO          = 3'h0;
  localparam pin_fn_t FN_C2_SERIAL_TX     = 3'h1;
  localparam pin_fn_t FN_C2_CROSSBAR_OUT  = 3'h2;
  localparam pin_fn_t FN_C2_CROSSBAR_IN   = 3'h3;
  localparam pin_fn_t FN_C2_CLOCK_OUT     = 3'h4;
  localparam pin_fn_t FN_RESET            = 3'h0;

  // Driver side of one two-way pin
  typedef struct packed {
    logic o;   // Level driven onto the pin
    logic oe;  // High while the pin is driven
  } pad_t;

  localparam pad_t       PAD_RESET      = 2'h0;
  localparam logic [4:0] PIN_SYNC_RESET = 5'h1f;
  localparam logic [4:0] GPIO_IN_RESET  = 5'h00;
  localparam logic       TEST_CLK_IDLE  = 1'h1;
  localparam logic       SERIAL_RX_IDLE = 1'h1;
  localparam logic       PERIPH_IDLE    = 1'h0;

  // Internal reset release delay, counted in mclk cycles
  localparam int         RST_RELEASE_CYCLES = 32;
  localparam int         RST_CNT_W          = 6;
  localparam logic [5:0] RST_CNT_LAST       = 6'(RST_RELEASE_CYCLES - 1);
  localparam logic [5:0] RST_CNT_RESET      = 6'h00;
  localparam logic [5:0] RST_CNT_FULL       = 6'(RST_RELEASE_CYCLES);

endpackage

// file: hdl/reset_release.sv
`timescale 1ns/100ps

// Holds the internal reset low while any source asks, then frees it on mclk
module reset_release
  import pin_mux_pkg::*;
(
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic req,
  output logic      rst_n
);

  logic [RST_CNT_W-1:0] cnt_r;    // Quiet cycles seen since the last request
  logic                 rst_n_r;  // Registered internal reset, active low

  // Count quiet cycles; release only on a clock edge so every domain sees it together
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r   <= RST_CNT_RESET;
      rst_n_r <= 1'b0;
    end else if (req) begin
      // Any request restarts the whole wait
      cnt_r   <= RST_CNT_RESET;
      rst_n_r <= 1'b0;
    end else if (cnt_r != RST_CNT_LAST) begin
      cnt_r   <= cnt_r + 6'h01;
    end else begin
      rst_n_r <= 1'b1;
    end
  end

  assign rst_n = rst_n_r;

endmodule

// file: hdl/pin_mux.sv
`timescale 1ns/100ps

// Function
// - Every pin starts on its primary function
// - Alternatives come only from the pin's enable bit, plus a select on C0 and C2
// - GPIO pins are individually input or output
// - Pin 1 defaults to test clock, alt GPIO
// - Reset pin low holds device in reset
// - Internal reset frees synchronously after fixed cycles
// - Reset pin as GPIO disables pin reset
// - Reset pin leaves reset in reset function
// - Port C bit 0 defaults GPIO, crystal/clock
// - Port C bit 1 defaults GPIO, crystal out
// - Port C bit 2 serial, crossbar, clock out
// - Clock output follows selected clock source
module pin_mux
  import pin_mux_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                nrst,
  input  wire logic [N_PINS-1:0]   pin_in,
  output pad_t      [N_PINS-1:0]   pin_pad,
  input  wire logic [N_PINS-1:0]   periph_en,
  input  wire logic                c0_alt_sel,
  input  wire logic [1:0]          c2_alt_sel,
  input  wire logic [N_PINS-1:0]   gpio_dir,
  input  wire logic [N_PINS-1:0]   gpio_out,
  output logic      [N_PINS-1:0]   gpio_in,
  input  wire logic [2:0]          clock_out_source_sel,
  input  wire logic [7:0]          clock_sources,
  input  wire logic                crystal_out_drive,
  output logic                     crystal_in,
  output logic                     ext_clock_in0,
  output logic                     test_clock,
  input  wire logic                serial0_transmit,
  input  wire logic                serial0_transmit_oe,
  output logic                     serial0_receive,
  input  wire logic                crossbar_out11,
  output logic                     crossbar_in2,
  input  wire logic                watchdog_reset_req,
  input  wire logic                sw_reset_req,
  output logic                     rst_int_n
);

  logic [N_PINS-1:0] sync1_r;       // First synchroniser stage, read by stage two only
  logic [N_PINS-1:0] sync2_r;       // Pin levels now safe on mclk
  pin_fn_t           fn_r   [N_PINS]; // Active function of each pin
  pin_fn_t           fn_nxt [N_PINS]; // Function requested by the selects
  pad_t [N_PINS-1:0] pad_nxt;       // Pin drive before the output flops
  logic [N_PINS-1:0] gpio_in_nxt;   // GPIO read value before its flop
  logic              clk_pick;      // Clock source chosen for clock output 0
  logic              pin_rst_req;   // Reset asked for by the reset pin
  logic              rst_req;       // Any reset source asking

  // Two-flop synchroniser on every pin; idle high so a pulled-up pin reads quiet
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= PIN_SYNC_RESET;
      sync2_r <= PIN_SYNC_RESET;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // Requested function: alternative only when its port enable bit is set
  always_comb begin
    fn_nxt[PIN_TCK] = periph_en[PIN_TCK] ? FN_TCK_GPIO : FN_TCK_TEST;
    fn_nxt[PIN_RST] = periph_en[PIN_RST] ? FN_RST_GPIO : FN_RST_PIN;
    // Port C bit 0 picks crystal input or external clock 0
    fn_nxt[PIN_C0]  = !periph_en[PIN_C0] ? FN_C0_GPIO :
                      (c0_alt_sel ? FN_C0_EXT_CLOCK_IN0 : FN_C0_CRYSTAL_IN);
    fn_nxt[PIN_C1]  = periph_en[PIN_C1] ? FN_C1_CRYSTAL_OUT : FN_C1_GPIO;
    // Port C bit 2 has four alternatives, codes one to four
    fn_nxt[PIN_C2]  = periph_en[PIN_C2] ? (pin_fn_t'({1'b0, c2_alt_sel}) + 3'h1)
                                        : FN_C2_GPIO;
  end

  // Function registers; the internal reset puts every pin back on its primary
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < N_PINS; i++) begin
        fn_r[i] <= FN_RESET;
      end
    end else begin
      for (int i = 0; i < N_PINS; i++) begin
        fn_r[i] <= rst_int_n ? fn_nxt[i] : FN_RESET;
      end
    end
  end

  // Clock source for clock output 0
  assign clk_pick = clock_sources[clock_out_source_sel];

  // Pin drive; undriven by default, then each pin takes either GPIO or its chosen alternative
  always_comb begin
    pad_nxt     = '0;
    gpio_in_nxt = GPIO_IN_RESET;
    // Port pins configured one by one as input or output
    if (fn_r[PIN_TCK] == FN_TCK_GPIO) begin
      pad_nxt[PIN_TCK]     = '{o: gpio_out[PIN_TCK], oe: gpio_dir[PIN_TCK]};
      gpio_in_nxt[PIN_TCK] = sync2_r[PIN_TCK];
    end
    if (fn_r[PIN_RST] == FN_RST_GPIO) begin
      pad_nxt[PIN_RST]     = '{o: gpio_out[PIN_RST], oe: gpio_dir[PIN_RST]};
      gpio_in_nxt[PIN_RST] = sync2_r[PIN_RST];
    end
    if (fn_r[PIN_C0] == FN_C0_GPIO) begin
      pad_nxt[PIN_C0]      = '{o: gpio_out[PIN_C0], oe: gpio_dir[PIN_C0]};
      gpio_in_nxt[PIN_C0]  = sync2_r[PIN_C0];
    end
    // Crystal output drives the resonator, otherwise GPIO
    if (fn_r[PIN_C1] == FN_C1_CRYSTAL_OUT) begin
      pad_nxt[PIN_C1]      = '{o: crystal_out_drive, oe: 1'b1};
    end else begin
      pad_nxt[PIN_C1]      = '{o: gpio_out[PIN_C1], oe: gpio_dir[PIN_C1]};
      gpio_in_nxt[PIN_C1]  = sync2_r[PIN_C1];
    end
    // Port C bit 2: exactly one source owns the pin
    unique case (fn_r[PIN_C2])
      FN_C2_GPIO: begin
        pad_nxt[PIN_C2]     = '{o: gpio_out[PIN_C2], oe: gpio_dir[PIN_C2]};
        gpio_in_nxt[PIN_C2] = sync2_r[PIN_C2];
      end
      // Single-wire mode lets the serial port turn the pin around
      FN_C2_SERIAL_TX:    pad_nxt[PIN_C2] = '{o: serial0_transmit,
                                              oe: serial0_transmit_oe};
      FN_C2_CROSSBAR_OUT: pad_nxt[PIN_C2] = '{o: crossbar_out11, oe: 1'b1};
      FN_C2_CROSSBAR_IN:  pad_nxt[PIN_C2] = PAD_RESET;
      FN_C2_CLOCK_OUT:    pad_nxt[PIN_C2] = '{o: clk_pick, oe: 1'b1};
      // Codes five to seven cannot be selected; leave the pin undriven
      default:            pad_nxt[PIN_C2] = PAD_RESET;
    endcase
  end

  // Pin drive and GPIO read flops; nothing is driven until a function asks
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_pad <= {N_PINS{PAD_RESET}};
      gpio_in <= GPIO_IN_RESET;
    end else begin
      pin_pad <= pad_nxt;
      gpio_in <= gpio_in_nxt;
    end
  end

  // Peripheral inputs; deselected ones sit at their idle level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      test_clock      <= TEST_CLK_IDLE;
      crystal_in      <= PERIPH_IDLE;
      ext_clock_in0   <= PERIPH_IDLE;
      serial0_receive <= SERIAL_RX_IDLE;
      crossbar_in2    <= PERIPH_IDLE;
    end else begin
      // Test clock is sampled, so it must run well below mclk
      test_clock      <= (fn_r[PIN_TCK] == FN_TCK_TEST) ? sync2_r[PIN_TCK]
                                                        : TEST_CLK_IDLE;
      crystal_in      <= (fn_r[PIN_C0] == FN_C0_CRYSTAL_IN) ? sync2_r[PIN_C0]
                                                            : PERIPH_IDLE;
      ext_clock_in0   <= (fn_r[PIN_C0] == FN_C0_EXT_CLOCK_IN0) ? sync2_r[PIN_C0]
                                                               : PERIPH_IDLE;
      serial0_receive <= (fn_r[PIN_C2] == FN_C2_SERIAL_TX) ? sync2_r[PIN_C2]
                                                           : SERIAL_RX_IDLE;
      crossbar_in2    <= (fn_r[PIN_C2] == FN_C2_CROSSBAR_IN) ? sync2_r[PIN_C2]
                                                             : PERIPH_IDLE;
    end
  end

  // Reset sources; the pin counts only while it carries its reset function
  assign pin_rst_req = (fn_r[PIN_RST] == FN_RST_PIN) && !sync2_r[PIN_RST];
  assign rst_req     = pin_rst_req || watchdog_reset_req || sw_reset_req;

  // Synchronous release of the internal reset
  reset_release u_reset_release (
    .mclk  (mclk),
    .nrst  (nrst),
    .req   (rst_req),
    .rst_n (rst_int_n)
  );

  // Helper for the checks: quiet cycles since the last reset request
  logic [RST_CNT_W-1:0] quiet_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      quiet_r <= RST_CNT_RESET;
    end else if (rst_req) begin
      quiet_r <= RST_CNT_RESET;
    end else if (quiet_r != RST_CNT_FULL) begin
      quiet_r <= quiet_r + 6'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_reset_seen;
    !rst_int_n;
  endsequence

  sequence s_primary_all;
    fn_r[PIN_TCK] == FN_TCK_TEST && fn_r[PIN_RST] == FN_RST_PIN &&
    fn_r[PIN_C0] == FN_C0_GPIO && fn_r[PIN_C1] == FN_C1_GPIO && fn_r[PIN_C2] == FN_C2_GPIO;
  endsequence

  property p_primary_after_reset;
    s_reset_seen |=> s_primary_all;
  endproperty
  a_primary_after_reset: assert property (p_primary_after_reset)
    else $error("pin left primary function during reset");

  property p_alt_needs_enable;
    rst_int_n && !periph_en[PIN_C2] |=> fn_r[PIN_C2] == FN_C2_GPIO;
  endproperty
  a_alt_needs_enable: assert property (p_alt_needs_enable)
    else $error("alternative taken without its enable");

  property p_gpio_output;
    fn_r[PIN_C0] == FN_C0_GPIO |=>
      pin_pad[PIN_C0].oe == $past(gpio_dir[PIN_C0]) &&
      pin_pad[PIN_C0].o == $past(gpio_out[PIN_C0]);
  endproperty
  a_gpio_output: assert property (p_gpio_output)
    else $error("gpio drive does not follow direction and data");

  property p_test_clock;
    fn_r[PIN_TCK] == FN_TCK_TEST |=> test_clock == $past(sync2_r[PIN_TCK]) && !pin_pad[PIN_TCK].oe;
  endproperty
  a_test_clock: assert property (p_test_clock)
    else $error("test clock not passed through");

  property p_pin_reset_holds;
    fn_r[PIN_RST] == FN_RST_PIN && !sync2_r[PIN_RST] |=> !rst_int_n [*2];
  endproperty
  a_pin_reset_holds: assert property (p_pin_reset_holds)
    else $error("reset pin low did not hold reset");

  property p_release_count;
    $rose(rst_int_n) |-> quiet_r == RST_CNT_FULL && !$past(rst_req);
  endproperty
  a_release_count: assert property (p_release_count)
    else $error("internal reset freed after wrong cycle count");

  property p_pin_reset_off;
    rst_int_n && fn_r[PIN_RST] == FN_RST_GPIO && !watchdog_reset_req && !sw_reset_req
      |=> rst_int_n;
  endproperty
  a_pin_reset_off: assert property (p_pin_reset_off)
    else $error("reset taken while reset pin is gpio");

  property p_crystal_in;
    fn_r[PIN_C0] != FN_C0_CRYSTAL_IN |=> crystal_in == PERIPH_IDLE;
  endproperty
  a_crystal_in: assert property (p_crystal_in)
    else $error("crystal input not idle when deselected");

  property p_crystal_out;
    fn_r[PIN_C1] == FN_C1_CRYSTAL_OUT |=>
      pin_pad[PIN_C1].oe && pin_pad[PIN_C1].o == $past(crystal_out_drive);
  endproperty
  a_crystal_out: assert property (p_crystal_out)
    else $error("crystal output not driven");

  property p_crossbar_out;
    fn_r[PIN_C2] == FN_C2_CROSSBAR_OUT |=>
      pin_pad[PIN_C2].oe && pin_pad[PIN_C2].o == $past(crossbar_out11);
  endproperty
  a_crossbar_out: assert property (p_crossbar_out)
    else $error("crossbar output not on pin");

  property p_clock_out;
    fn_r[PIN_C2] == FN_C2_CLOCK_OUT |=>
      pin_pad[PIN_C2].oe && pin_pad[PIN_C2].o == $past(clk_pick);
  endproperty
  a_clock_out: assert property (p_clock_out)
    else $error("clock output not the selected source");

  property p_crossbar_in_idle;
    fn_r[PIN_C2] != FN_C2_CROSSBAR_IN |=> crossbar_in2 == PERIPH_IDLE;
  endproperty
  a_crossbar_in_idle: assert property (p_crossbar_in_idle)
    else $error("crossbar input not idle when deselected");

endmodule

// file: verif/pin_board_model.sv
`timescale 1ns/100ps

// Board around the five pins: pad drive wins, then an outside source, then pull or noise
module pin_board_model
  import pin_mux_pkg::*;
(
  input  wire logic              mclk,
  input  wire pad_t [N_PINS-1:0] pin_pad,
  input  wire logic [N_PINS-1:0] ext_en,
  input  wire logic [N_PINS-1:0] ext_val,
  output logic      [N_PINS-1:0] pin_in
);
  logic [N_PINS-1:0] noise_r = 5'h0a;  // Floating level, never a stable guess

  // Unpulled floating pins wander every cycle so stale values never pass
  always_ff @(posedge mclk) begin
    noise_r <= ~noise_r;
  end

  // Wire resolution per pin
  always_comb begin
    for (int i = 0; i < N_PINS; i++) begin
      if (pin_pad[i].oe)
        pin_in[i] = pin_pad[i].o;
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (i == PIN_TCK)
        pin_in[i] = 1'h1;  // Test clock pin has a pull-up
      else
        pin_in[i] = noise_r[i];
    end
  end
endmodule

// file: verif/test_pin_function_select_and_reset_pin.sv
`timescale 1ns/100ps

// Pin mux bench: function selects, pin paths and reset release
module test_pin_function_select_and_reset_pin
  import pin_mux_pkg::*;
;
  logic              mclk = 1'h0;
  logic              nrst = 1'h0;
  logic [N_PINS-1:0] pin_in;
  pad_t [N_PINS-1:0] pin_pad;
  logic [N_PINS-1:0] periph_en = 5'h00;
  logic              c0_sel = 1'h0;
  logic [1:0]        c2_sel = 2'h0;
  logic [N_PINS-1:0] gpio_dir = 5'h00;
  logic [N_PINS-1:0] gpio_out = 5'h00;
  logic [N_PINS-1:0] gpio_in;
  logic [2:0]        clk_sel = 3'h0;
  logic [7:0]        clk_src = 8'ha5;  // Fixed levels, one per source
  logic              xo_drive = 1'h0;
  logic              cry_in, clk0_in, tclk, rx, xb_in;
  logic              tx = 1'h0;
  logic              tx_oe = 1'h0;
  logic              xb_out = 1'h0;
  logic              wd_req = 1'h0;
  logic              sw_req = 1'h0;
  logic              rst_int_n;
  logic [N_PINS-1:0] ext_en = 5'h1f;   // Board drives every pin by default
  logic [N_PINS-1:0] ext_val = 5'h02;  // Reset pin held high
  int                fails = 0;
  int                compares = 0;
  int                n;

  // Free-running system clock
  always #4 mclk = ~mclk;

  pin_mux DUT (.mclk(mclk), .nrst(nrst), .pin_in(pin_in), .pin_pad(pin_pad),
    .periph_en(periph_en), .c0_alt_sel(c0_sel), .c2_alt_sel(c2_sel), .gpio_dir(gpio_dir),
    .gpio_out(gpio_out), .gpio_in(gpio_in), .clock_out_source_sel(clk_sel),
    .clock_sources(clk_src), .crystal_out_drive(xo_drive), .crystal_in(cry_in),
    .ext_clock_in0(clk0_in), .test_clock(tclk), .serial0_transmit(tx),
    .serial0_transmit_oe(tx_oe), .serial0_receive(rx), .crossbar_out11(xb_out),
    .crossbar_in2(xb_in), .watchdog_reset_req(wd_req), .sw_reset_req(sw_req),
    .rst_int_n(rst_int_n));

  pin_board_model board (.mclk(mclk), .pin_pad(pin_pad), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in));

  // Verdict and end of run
  task automatic print_verdict();
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One comparison
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Let selects and the three-flop input path settle
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask

  // Cycles until internal reset frees, bounded
  task automatic wait_up(output int cnt);
    cnt = 0;
    while (rst_int_n !== 1'h1 && cnt < 200) begin
      @(negedge mclk);
      cnt++;
    end
    if (cnt >= 200) begin
      fails++;
      print_verdict();
    end
  endtask

  // Reset state, release delay, primary functions
  task automatic t_power_up();
    chk("pads in reset", 8'h00, pin_pad);
    chk("tclk in reset", 8'h01, tclk);
    nrst = 1'h1;
    wait_up(n);
    chk("release cycles", 8'd32, n[7:0]);
    for (int v = 0; v < 2; v++) begin
      ext_val = {v[0], ~v[0], v[0], 1'h1, v[0]};
      tick(5);
      chk("tclk follows", v[0], tclk);
      chk("gpio in", {3'h0, v[0], ~v[0], v[0], 2'h0}, gpio_in);
      chk("idle inputs", 8'h00, {cry_in, clk0_in, xb_in, ~rx});
    end
  endtask

  // Per-pin direction on port C pins
  task automatic t_gpio();
    gpio_dir = 5'h1f;
    gpio_out = 5'h15;
    tick(3);
    chk("gpio pads", 8'h37, {pin_pad[4], pin_pad[3], pin_pad[2]});
    gpio_dir = 5'h08;
    gpio_out[PIN_C1] = 1'h1;  // Opposite of the board level, so the pad must win
    tick(5);
    chk("gpio oe", 8'h02, {pin_pad[4].oe, pin_pad[3].oe, pin_pad[2].oe});
    chk("loopback", 8'h01, gpio_in[PIN_C1]);
    gpio_dir = 5'h00;
  endtask

  // Test clock pin as GPIO
  task automatic t_tck_alt();
    periph_en = 5'h01;
    for (int v = 0; v < 2; v++) begin
      ext_val[PIN_TCK] = v[0];
      tick(5);
      chk("tclk idle", 8'h01, tclk);
      chk("tck gpio in", v[0], gpio_in[PIN_TCK]);
    end
    ext_val[PIN_TCK] = 1'h0;
    tick(5);
    ext_en[PIN_TCK] = 1'h0;  // Released pin rests on its pull-up
    tick(5);
    chk("tck pull-up", 8'h01, gpio_in[PIN_TCK]);
    ext_en = 5'h1f;
  endtask

  // Crystal input and clock input 0
  task automatic t_c0();
    periph_en = 5'h04;
    for (int s = 0; s < 2; s++) begin
      for (int v = 0; v < 2; v++) begin
        c0_sel = s[0];
        ext_val[PIN_C0] = v[0];
        tick(5);
        chk("crystal in", (s == 0) ? v[0] : 1'h0, cry_in);
        chk("clock in 0", (s == 1) ? v[0] : 1'h0, clk0_in);
        chk("c0 gpio idle", 8'h00, gpio_in[PIN_C0]);
      end
    end
  endtask

  // Crystal output and port C bit 2 alternatives
  task automatic t_c1_c2();
    periph_en = 5'h18;
    for (int v = 0; v < 2; v++) begin
      xo_drive = v[0];
      tx = v[0];
      tx_oe = 1'h1;
      ext_val[PIN_C2] = v[0];
      c2_sel = 2'h0;
      tick(3);
      chk("crystal out", {v[0], 1'h1}, pin_pad[3]);
      chk("serial tx", {v[0], 1'h1}, pin_pad[4]);
      tx_oe = 1'h0;
      tick(5);
      chk("serial rx", {1'h0, v[0]}, {pin_pad[4].oe, rx});
      c2_sel = 2'h1;
      xb_out = ~v[0];
      tick(5);
      chk("crossbar out", {~v[0], 1'h1}, pin_pad[4]);
      chk("rx idle", 8'h01, {xb_in, rx});
      c2_sel = 2'h2;
      tick(5);
      chk("crossbar in", {1'h0, v[0]}, {pin_pad[4].oe, xb_in});
    end
    c2_sel = 2'h3;
    for (int s = 0; s < 8; s++) begin
      clk_sel = s[2:0];
      tick(4);
      chk("clock out", {clk_src[s], 1'h1}, pin_pad[4]);
    end
  endtask

  // Pin reset, pin reset off in GPIO use, watchdog and software resets
  task automatic t_resets();
    periph_en = 5'h00;
    ext_val[PIN_RST] = 1'h0;
    tick(4);
    chk("pin reset", 8'h00, rst_int_n);
    ext_val[PIN_RST] = 1'h1;
    wait_up(n);
    chk("pin release", 8'd34, n[7:0]);
    periph_en = 5'h02;
    tick(3);
    ext_val[PIN_RST] = 1'h0;
    tick(10);
    chk("pin reset off", 8'h01, rst_int_n);
    chk("d4 gpio in", 8'h00, gpio_in[PIN_RST]);
    ext_val[PIN_RST] = 1'h1;
    tick(4);
    chk("d4 gpio high", 8'h01, gpio_in[PIN_RST]);
    for (int k = 0; k < 2; k++) begin
      wd_req = (k == 0);
      sw_req = (k == 1);
      tick(2);
      chk("req reset", 8'h00, rst_int_n);
      wd_req = 1'h0;
      sw_req = 1'h0;
      wait_up(n);
      chk("req release", 8'd32, n[7:0]);
    end
  endtask

  // Main sequence
  initial begin
    tick(2);
    t_power_up();
    t_gpio();
    t_tck_alt();
    t_c0();
    t_c1_c2();
    t_resets();
    print_verdict();
  end
endmodule
